// ---- rtl/phy_basic_control_register.sv ----
// Front end and per-port control outputs of the PHY basic control register.
`timescale 1ns/1ns
`include "phy_ctrl_params.svh"

// Behaviour
// - Writing one to bit 15 resets the PHY; bit self-clears, reads zero after reset.
// - Loopback bit loops monitor-port frames back at this port's MAC/PHY interface.
// - Loopback bit at addresses 3, 4, 5 loops back ports 3, 4, 5.
// - Forced speed bit selects 100 Mbps when one, 10 Mbps when zero; resets one.
// - Auto-negotiation enable bit turns negotiation on when one; resets to one.
// - Power down bit powers the PHY down; zero is normal; resets zero.
// - Isolate bit isolates the PHY from its transmit pair; resets zero.
// - Writing one to the restart bit restarts auto-negotiation; resets zero.
// - Forced duplex bit selects full duplex when one, half when zero; resets one.
// - Crossover algorithm bit picks alternate algorithm when one; resets to one.
// - With auto crossover off, force MDI bit picks MDI or MDIX; resets zero.
// - Crossover disable bit turns automatic MDI/MDIX detection off; resets zero.
// - Far-end-fault disable bit turns far-end-fault detection off; resets zero.
// - The same register is also reachable over the byte-wide serial path.
module phy_basic_control_register (
  // Clock and reset.
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  // Management serial access, one word per request.
  input  wire logic                       miim_wr,
  input  wire logic                       miim_rd,
  input  wire logic [4:0]                 miim_phyad,
  input  wire logic [4:0]                 miim_regad,
  input  wire phy_ctrl_pkg::ctrl_word_type miim_wdata,
  output      phy_ctrl_pkg::ctrl_word_type miim_rdata,
  output      logic                       miim_ack,
  output      logic                       miim_hit,
  // Byte-wide serial access.
  input  wire logic                       spi_wr,
  input  wire logic                       spi_rd,
  input  wire logic [7:0]                 spi_addr,
  input  wire logic [7:0]                 spi_wdata,
  output      logic [7:0]                 spi_rdata,
  output      logic                       spi_ack,
  output      logic                       spi_hit,
  // Per-port controls to the PHY and MAC, bit 0 is port 1.
  output      logic [`NUM_PORTS-1:0]      phy_soft_reset,
  output      logic [`NUM_PORTS-1:0]      mac_loopback,
  output      logic [`NUM_PORTS-1:0]      speed_100,
  output      logic [`NUM_PORTS-1:0]      autoneg_enable,
  output      logic [`NUM_PORTS-1:0]      power_down,
  output      logic [`NUM_PORTS-1:0]      phy_isolate,
  output      logic [`NUM_PORTS-1:0]      autoneg_restart,
  output      logic [`NUM_PORTS-1:0]      full_duplex,
  output      logic [`NUM_PORTS-1:0]      alt_crossover_algorithm_select,
  output      logic [`NUM_PORTS-1:0]      force_mdi,
  output      logic [`NUM_PORTS-1:0]      crossover_disable,
  output      logic [`NUM_PORTS-1:0]      far_end_fault_disable,
  output      logic [`NUM_PORTS-1:0]      forced_link_mode
);
  import phy_ctrl_pkg::*;

  logic                   rst_meta_b;
  logic                   rst_sync_b;
  logic                   miim_active;
  logic                   spi_active;
  logic                   spi_taken;
  logic [`NUM_PORTS-1:0]  miim_sel;
  logic [`NUM_PORTS-1:0]  spi_sel;
  ctrl_word_type          ctrl_word [`NUM_PORTS];
  ctrl_word_type          miim_read_word;
  ctrl_word_type          spi_read_word;
  ctrl_word_type          spi_wmask;
  ctrl_word_type          next_miim_rdata;
  logic [7:0]             next_spi_rdata;
  logic                   next_miim_ack;
  logic                   next_miim_hit;
  logic                   next_spi_ack;
  logic                   next_spi_hit;

  // Reset is asserted at once but released two clocks late so every flop leaves reset on one edge.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // A word access wins a same-cycle collision; the byte access is refused and gets no ack.
  assign miim_active = miim_wr | miim_rd;
  assign spi_active  = spi_wr | spi_rd;
  assign spi_taken   = spi_active & ~miim_active;

  // The odd byte address carries the low half of the word, the even one the high half.
  assign spi_wmask = spi_addr[0] ? `MASK_LOW_BYTE : `MASK_HIGH_BYTE;

  // One register instance per port, each with its own decode.
  for (genvar i = 0; i < `NUM_PORTS; i++) begin : port_gen
    phy_ctrl_if port_bus ();

    // Port i answers at management address i+1, so ports 1 to 5 sit at addresses 1 to 5.
    assign miim_sel[i] = miim_active
                         && (miim_phyad == `PORT_ADDR_FIRST + 5'(i))
                         && (miim_regad == `MIIM_REG_CTRL);
    assign spi_sel[i]  = spi_taken
                         && (spi_addr[7:4] == 4'(i + 1))
                         && (spi_addr[3:1] == `SPI_REG_IDX);

    // Write strobe, mask and data for this port.
    assign port_bus.wr_en = (miim_sel[i] & miim_wr) | (spi_sel[i] & spi_wr);
    assign port_bus.wmask = miim_sel[i] ? `MASK_ALL : spi_wmask;
    assign port_bus.wdata = miim_sel[i] ? miim_wdata : {spi_wdata, spi_wdata};

    phy_port_ctrl port_ctrl (
      .mclk       (mclk),
      .rst_sync_b (rst_sync_b),
      .bus        (port_bus.port_side)
    );

    // Every control output except autoneg_restart and forced_link_mode is a bit of the port's register flops, with no logic between.
    assign ctrl_word[i]                      = port_bus.ctrl;
    assign phy_soft_reset[i]                 = port_bus.ctrl[`BIT_SOFT_RESET];
    assign mac_loopback[i]                   = port_bus.ctrl[`BIT_LOOPBACK];
    assign speed_100[i]                      = port_bus.ctrl[`BIT_SPEED_100];
    assign autoneg_enable[i]                 = port_bus.ctrl[`BIT_AUTONEG_EN];
    assign power_down[i]                     = port_bus.ctrl[`BIT_POWER_DOWN];
    assign phy_isolate[i]                    = port_bus.ctrl[`BIT_ISOLATE];
    assign autoneg_restart[i]                = port_bus.restart_pulse;
    assign full_duplex[i]                    = port_bus.ctrl[`BIT_FULL_DUPLEX];
    assign alt_crossover_algorithm_select[i] = port_bus.ctrl[`BIT_ALT_XOVER];
    assign force_mdi[i]                      = port_bus.ctrl[`BIT_FORCE_MDI];
    assign crossover_disable[i]              = port_bus.ctrl[`BIT_XOVER_DIS];
    assign far_end_fault_disable[i]          = port_bus.ctrl[`BIT_FEF_DIS];
    // Speed and duplex apply only while this is high; the PHY ignores them otherwise.
    assign forced_link_mode[i]               = port_bus.forced_mode;
  end

  // Read multiplexers; reserved bits and bits owned elsewhere return zero.
  always_comb begin
    miim_read_word = `DATA_ZERO;
    spi_read_word  = `DATA_ZERO;
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (miim_sel[p]) begin
        miim_read_word = ctrl_word[p] & `CTRL_READ_MASK;
      end
      if (spi_sel[p]) begin
        spi_read_word = ctrl_word[p] & `CTRL_READ_MASK;
      end
    end
  end

  // Next answer values; a read that misses returns zero with the hit flag low.
  always_comb begin
    next_miim_ack   = miim_active;
    next_miim_hit   = |miim_sel;
    next_miim_rdata = miim_rd ? miim_read_word : `DATA_ZERO;
    next_spi_ack    = spi_taken;
    next_spi_hit    = |spi_sel;
    next_spi_rdata  = `BYTE_ZERO;
    if (spi_rd && spi_taken) begin
      next_spi_rdata = spi_addr[0] ? spi_read_word[7:0] : spi_read_word[15:8];
    end
  end

  // Answer registers; each stands for one cycle after the request edge.
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      miim_ack   <= 1'b0;
      miim_hit   <= 1'b0;
      miim_rdata <= `DATA_ZERO;
      spi_ack    <= 1'b0;
      spi_hit    <= 1'b0;
      spi_rdata  <= `BYTE_ZERO;
    end else begin
      miim_ack   <= next_miim_ack;
      miim_hit   <= next_miim_hit;
      miim_rdata <= next_miim_rdata;
      spi_ack    <= next_spi_ack;
      spi_hit    <= next_spi_hit;
      spi_rdata  <= next_spi_rdata;
    end
  end
endmodule

// ---- include/phy_ctrl_params.svh ----
// Named constants for the per-port PHY basic control register block.
`ifndef PHY_CTRL_PARAMS_SVH
`define PHY_CTRL_PARAMS_SVH

// Register geometry.
`define CTRL_WIDTH        16
`define NUM_PORTS         5
`define PORT_ADDR_FIRST   5'h01
`define MIIM_REG_CTRL     5'h00

// Bit positions inside the control word.
`define BIT_SOFT_RESET    15
`define BIT_LOOPBACK      14
`define BIT_SPEED_100     13
`define BIT_AUTONEG_EN    12
`define BIT_POWER_DOWN    11
`define BIT_ISOLATE       10
`define BIT_AUTONEG_RST   9
`define BIT_FULL_DUPLEX   8
`define BIT_ALT_XOVER     5
`define BIT_FORCE_MDI     4
`define BIT_XOVER_DIS     3
`define BIT_FEF_DIS       2

// Reset value, writable bits and bits this block returns on a read.
`define CTRL_RESET_VALUE  16'h3120
`define CTRL_WRITABLE     16'hff3c
`define CTRL_READ_MASK    16'hff3c
`define MASK_ALL          16'hffff
`define MASK_HIGH_BYTE    16'hff00
`define MASK_LOW_BYTE     16'h00ff
`define DATA_ZERO         16'h0000
`define BYTE_ZERO         8'h00

// Byte-wide access path: port n answers where the high nibble of the address is n.
`define SPI_REG_IDX       3'h6

// Soft reset length.
`define CLK_PERIOD_NS     100
`define SOFT_RESET_NS     500
`define SOFT_RESET_CYCLES ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_WIDTH       4
`define TIMER_ZERO        4'h0
`define TIMER_ONE         4'h1

`endif

// ---- include/phy_ctrl_pkg.sv ----
// Types shared by the PHY basic control register modules.
package phy_ctrl_pkg;

  // One-hot states of the per-port soft reset sequencer.
  typedef enum logic [1:0] {
    SR_IDLE = 2'b01,
    SR_BUSY = 2'b10
  } soft_reset_state_type;

  // Sixteen-bit control word.
  typedef logic [15:0] ctrl_word_type;

endpackage

// ---- include/phy_ctrl_if.sv ----
// Carrier between the register front end and one port's control register.
`timescale 1ns/1ns
interface phy_ctrl_if;
  import phy_ctrl_pkg::*;

  logic          wr_en;
  ctrl_word_type wmask;
  ctrl_word_type wdata;
  ctrl_word_type ctrl;
  logic          restart_pulse;
  logic          forced_mode;

  modport front_side (
    output wr_en,
    output wmask,
    output wdata,
    input  ctrl,
    input  restart_pulse,
    input  forced_mode
  );

  modport port_side (
    input  wr_en,
    input  wmask,
    input  wdata,
    output ctrl,
    output restart_pulse,
    output forced_mode
  );
endinterface

// ---- rtl/phy_port_ctrl.sv ----
// One port's control register with its self-clearing soft reset sequencer.
`timescale 1ns/1ns
`include "phy_ctrl_params.svh"
module phy_port_ctrl (
  // Clock and synchronised reset.
  input wire logic     mclk,
  input wire logic     rst_sync_b,
  // Access from the register front end.
  phy_ctrl_if.port_side bus
);
  import phy_ctrl_pkg::*;

  soft_reset_state_type        state;
  soft_reset_state_type        next_state;
  ctrl_word_type               ctrl;
  ctrl_word_type               next_ctrl;
  logic [`TIMER_WIDTH-1:0]     timer;
  logic [`TIMER_WIDTH-1:0]     next_timer;
  logic                        restart_pulse;
  logic                        next_restart_pulse;
  logic                        forced_mode;
  logic                        next_forced_mode;

  // Next-state logic; writes are merged under the byte mask so a byte-wide access keeps the other half.
  always_comb begin
    next_state         = state;
    next_ctrl          = ctrl;
    next_timer         = timer;
    next_restart_pulse = 1'b0;
    unique case (state)
      SR_IDLE: begin
        if (bus.wr_en) begin
          next_ctrl = (ctrl & ~bus.wmask) | (bus.wdata & bus.wmask & `CTRL_WRITABLE);
          if (bus.wmask[`BIT_SOFT_RESET] && bus.wdata[`BIT_SOFT_RESET]) begin
            next_state = SR_BUSY;
            next_timer = `TIMER_WIDTH'(`SOFT_RESET_CYCLES - 1);
          end
          if (bus.wmask[`BIT_AUTONEG_RST] && bus.wdata[`BIT_AUTONEG_RST]) begin
            next_restart_pulse = 1'b1;
          end
        end
      end
      SR_BUSY: begin
        // Writes are dropped while the PHY is in reset; the word returns to defaults at the end.
        if (timer == `TIMER_ZERO) begin
          next_state = SR_IDLE;
          next_ctrl  = `CTRL_RESET_VALUE;
        end else begin
          next_timer = timer - `TIMER_ONE;
        end
      end
    endcase
    next_forced_mode = ~next_ctrl[`BIT_AUTONEG_EN];
  end

  // State registers; the reset value selects 100 Mbps, full duplex, negotiation on.
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state         <= SR_IDLE;
      ctrl          <= `CTRL_RESET_VALUE;
      timer         <= `TIMER_ZERO;
      restart_pulse <= 1'b0;
      forced_mode   <= 1'b0;
    end else begin
      state         <= next_state;
      ctrl          <= next_ctrl;
      timer         <= next_timer;
      restart_pulse <= next_restart_pulse;
      forced_mode   <= next_forced_mode;
    end
  end

  assign bus.ctrl          = ctrl;
  assign bus.restart_pulse = restart_pulse;
  assign bus.forced_mode   = forced_mode;
endmodule

// ---- dv/phy_basic_control_register_properties.sv ----
// Port-level checks for the PHY basic control register.
`timescale 1ns/1ns
`include "phy_ctrl_params.svh"
module phy_basic_control_register_properties (
  // Clock and reset.
  input wire logic                        mclk,
  input wire logic                        rst_b,
  // Word path.
  input wire logic                        miim_wr,
  input wire logic                        miim_rd,
  input wire logic [4:0]                  miim_phyad,
  input wire logic [4:0]                  miim_regad,
  input wire phy_ctrl_pkg::ctrl_word_type miim_wdata,
  input wire phy_ctrl_pkg::ctrl_word_type miim_rdata,
  input wire logic                        miim_ack,
  input wire logic                        miim_hit,
  // Port controls.
  input wire logic [`NUM_PORTS-1:0]       phy_soft_reset,
  input wire logic [`NUM_PORTS-1:0]       mac_loopback,
  input wire logic [`NUM_PORTS-1:0]       speed_100,
  input wire logic [`NUM_PORTS-1:0]       autoneg_enable,
  input wire logic [`NUM_PORTS-1:0]       autoneg_restart,
  input wire logic [`NUM_PORTS-1:0]       forced_link_mode
);
  import phy_ctrl_pkg::*;
  // One clock domain, so clock and reset are given once.
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  chk_ack_after_req: assert property ((miim_wr || miim_rd) |=> miim_ack)
    else $error("word request not answered in the next cycle");
  chk_ack_no_req: assert property (!(miim_wr || miim_rd) |=> !miim_ack)
    else $error("word answer without a request");
  chk_miss_read_zero: assert property (
    miim_rd && (miim_regad != 5'h00 || miim_phyad == 5'h00 || miim_phyad > 5'h05)
    |=> !miim_hit && miim_rdata == 16'h0000)
    else $error("unmapped read gave a hit or data");
  chk_hit_decode: assert property (
    miim_rd && miim_regad == 5'h00 && miim_phyad inside {[5'h01:5'h05]} |=> miim_hit)
    else $error("port register read gave no hit");
  chk_reserved_zero: assert property (miim_ack |-> miim_rdata[7:6] == 2'b00)
    else $error("reserved bits read nonzero");
  chk_soft_reset_len: assert property (
    $rose(phy_soft_reset[0]) |-> phy_soft_reset[0] [*5] ##1 !phy_soft_reset[0])
    else $error("soft reset length wrong");
  chk_restart_cause: assert property (
    miim_wr && miim_phyad == 5'h01 && miim_regad == 5'h00 && miim_wdata[9] && !miim_wdata[15]
    && !phy_soft_reset[0] |=> autoneg_restart[0])
    else $error("restart write gave no pulse");
  chk_write_applies: assert property (
    miim_wr && miim_phyad == 5'h01 && miim_regad == 5'h00 && !miim_wdata[15] && !phy_soft_reset[0]
    |=> mac_loopback[0] == $past(miim_wdata[14]) && speed_100[0] == $past(miim_wdata[13])
    && autoneg_enable[0] == $past(miim_wdata[12]))
    else $error("written control bits not applied");
  chk_forced_mode: assert property (
    $stable(autoneg_enable) ##1 $stable(autoneg_enable) |-> forced_link_mode == ~autoneg_enable)
    else $error("forced mode does not follow negotiation enable");
endmodule

bind phy_basic_control_register phy_basic_control_register_properties CHK (.mclk, .rst_b, .miim_wr, .miim_rd,
  .miim_phyad, .miim_regad, .miim_wdata, .miim_rdata, .miim_ack, .miim_hit, .phy_soft_reset, .mac_loopback,
  .speed_100, .autoneg_enable, .autoneg_restart, .forced_link_mode);

// ---- dv/phy_mgmt_model.sv ----
// Management controller model issuing word and byte register accesses.
`timescale 1ns/1ns
module phy_mgmt_model (
  // Clock.
  input  wire logic                        mclk,
  // Word path.
  output      logic                        miim_wr,
  output      logic                        miim_rd,
  output      logic [4:0]                  miim_phyad,
  output      logic [4:0]                  miim_regad,
  output      phy_ctrl_pkg::ctrl_word_type miim_wdata,
  input  wire phy_ctrl_pkg::ctrl_word_type miim_rdata,
  input  wire logic                        miim_ack,
  // Byte path.
  output      logic                        spi_wr,
  output      logic                        spi_rd,
  output      logic [7:0]                  spi_addr,
  output      logic [7:0]                  spi_wdata,
  input  wire logic [7:0]                  spi_rdata,
  input  wire logic                        spi_ack
);
  import phy_ctrl_pkg::*;
  int misses = 0;

  // Idle at time zero so no request is seen during reset.
  initial begin
    {miim_wr, miim_rd, spi_wr, spi_rd} = 4'h0;
    {miim_phyad, miim_regad, miim_wdata, spi_addr, spi_wdata} = 42'h0;
  end

  // One request pulse, then a bounded wait for the answer; a is {phy, reg} or the byte address.
  task automatic access(input logic spi, input logic wr, input logic [9:0] a,
                        input ctrl_word_type wd, output ctrl_word_type rd);
    int n;
    @(posedge mclk);
    #1;
    if (spi) begin
      {spi_wr, spi_rd, spi_addr, spi_wdata} = {wr, !wr, a[7:0], wd[7:0]};
    end else begin
      {miim_wr, miim_rd, miim_phyad, miim_regad, miim_wdata} = {wr, !wr, a, wd};
    end
    @(posedge mclk);
    #1;
    {miim_wr, miim_rd, spi_wr, spi_rd} = 4'h0;
    // Released data lines show the inverse, never a stale copy.
    miim_wdata = ~miim_wdata;
    spi_wdata = ~spi_wdata;
    for (n = 0; n < 4 && (spi ? spi_ack : miim_ack) !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
    end
    rd = spi ? {8'h00, spi_rdata} : miim_rdata;
    misses += (n == 4);
  endtask
endmodule

// ---- dv/phy_basic_control_register_test.sv ----
// Self-checking testbench for the PHY basic control register.
`timescale 1ns/1ns
`include "phy_ctrl_params.svh"
module phy_basic_control_register_test;
  import phy_ctrl_pkg::*;
  logic                  mclk, rst_b, miim_wr, miim_rd, miim_ack, miim_hit, spi_wr, spi_rd, spi_ack, spi_hit;
  logic [4:0]            miim_phyad, miim_regad;
  ctrl_word_type         miim_wdata, miim_rdata, rd;
  logic [7:0]            spi_addr, spi_wdata, spi_rdata;
  logic [`NUM_PORTS-1:0] phy_soft_reset, mac_loopback, speed_100, autoneg_enable, power_down, phy_isolate;
  logic [`NUM_PORTS-1:0] autoneg_restart, full_duplex, alt_crossover_algorithm_select, force_mdi;
  logic [`NUM_PORTS-1:0] crossover_disable, far_end_fault_disable, forced_link_mode;
  int                    fail_count = 0;
  int                    n_tests = 0;
  int                    p;
  // Places outside the served map: no such port, a register other than 0, and the top register.
  logic [9:0]            unmapped [3] = '{10'h0c0, 10'h021, 10'h03f};

  phy_basic_control_register DUT (.mclk, .rst_b, .miim_wr, .miim_rd, .miim_phyad, .miim_regad, .miim_wdata,
    .miim_rdata, .miim_ack, .miim_hit, .spi_wr, .spi_rd, .spi_addr, .spi_wdata, .spi_rdata, .spi_ack, .spi_hit,
    .phy_soft_reset, .mac_loopback, .speed_100, .autoneg_enable, .power_down, .phy_isolate, .autoneg_restart,
    .full_duplex, .alt_crossover_algorithm_select, .force_mdi, .crossover_disable, .far_end_fault_disable,
    .forced_link_mode);
  phy_mgmt_model MGMT (.mclk, .miim_wr, .miim_rd, .miim_phyad, .miim_regad, .miim_wdata, .miim_rdata,
    .miim_ack, .spi_wr, .spi_rd, .spi_addr, .spi_wdata, .spi_rdata, .spi_ack);

  // 100 ns clock.
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  // Port outputs packed back into register bit positions; the restart pulse is left out.
  function automatic ctrl_word_type ctl(input int i);
    return {phy_soft_reset[i], mac_loopback[i], speed_100[i], autoneg_enable[i], power_down[i], phy_isolate[i],
            1'b0, full_duplex[i], 2'b00, alt_crossover_algorithm_select[i], force_mdi[i], crossover_disable[i],
            far_end_fault_disable[i], 2'b00};
  endfunction

  task automatic check(input ctrl_word_type seen, input ctrl_word_type exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    fail_count += MGMT.misses;
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The whole run needs under a hundred cycles; this bound only catches a hang.
  initial begin
    repeat (3000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end

  initial begin
    rst_b = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge mclk);
    // Defaults on every port, both as read back and at the outputs.
    for (p = 1; p <= 5; p++) begin
      MGMT.access(1'b0, 1'b0, {p[4:0], 5'h00}, 16'h0000, rd);
      check(rd, 16'h3120);
      check(ctl(p - 1), 16'h3120);
    end
    $display("test reset_defaults done");
    // Every writable bit but soft reset and negotiation enable set then cleared on each port, restart pulsed along the way.
    for (p = 1; p <= 5; p++) begin
      MGMT.access(1'b0, 1'b1, {p[4:0], 5'h00}, 16'h6fff, rd);
      check(ctl(p - 1), 16'h6d3c);
      check({15'h0000, autoneg_restart[p - 1]}, 16'h0001);
      check({15'h0000, forced_link_mode[p - 1]}, 16'h0001);
      MGMT.access(1'b0, 1'b0, {p[4:0], 5'h00}, 16'h0000, rd);
      check(rd, 16'h6f3c);
      MGMT.access(1'b0, 1'b1, {p[4:0], 5'h00}, 16'h0000, rd);
      check(ctl(p - 1), 16'h0000);
    end
    $display("test write_all_ports done");
    // Unmapped places take no write and read as zero.
    foreach (unmapped[i]) begin
      MGMT.access(1'b0, 1'b1, unmapped[i], 16'h7fff, rd);
      MGMT.access(1'b0, 1'b0, unmapped[i], 16'h0000, rd);
      check(rd, 16'h0000);
      check({15'h0000, miim_hit}, 16'h0000);
    end
    check(ctl(0), 16'h0000);
    $display("test unmapped done");
    // Byte path: high and low halves of port 2.
    MGMT.access(1'b1, 1'b1, 10'h02c, 16'h007f, rd);
    MGMT.access(1'b1, 1'b1, 10'h02d, 16'h00ff, rd);
    MGMT.access(1'b1, 1'b0, 10'h02c, 16'h0000, rd);
    check(rd, 16'h007f);
    check({15'h0000, spi_hit}, 16'h0001);
    MGMT.access(1'b1, 1'b0, 10'h02d, 16'h0000, rd);
    check(rd, 16'h003c);
    $display("test byte_path done");
    // Soft reset through the byte path self-clears and restores the defaults.
    MGMT.access(1'b1, 1'b1, 10'h01c, 16'h0080, rd);
    check({15'h0000, phy_soft_reset[0]}, 16'h0001);
    // A word write while the reset runs is dropped, so the register still holds only the reset bit.
    MGMT.access(1'b0, 1'b1, 10'h020, 16'h0000, rd);
    MGMT.access(1'b0, 1'b0, 10'h020, 16'h0000, rd);
    check(rd, 16'h8000);
    repeat (6) @(posedge mclk);
    #1;
    MGMT.access(1'b0, 1'b0, 10'h020, 16'h0000, rd);
    check(rd, 16'h3120);
    $display("test soft_reset done");
    print_verdict();
  end
endmodule
